// *** inc/gpc_pkg.sv ***
`default_nettype none
package gpc_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] GPC_OFF_DIR = 8'h00;
    localparam logic [7:0] GPC_OFF_OUT = 8'h04;
    localparam logic [7:0] GPC_OFF_IN = 8'h08;
    localparam logic [7:0] GPC_OFF_CTRL = 8'h0c;
    localparam logic [7:0] GPC_OFF_EXT_EN = 8'h10;
    localparam logic [7:0] GPC_OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] GPC_OFF_IRQ_MASK = 8'h18;
    // Field positions
    localparam int GPC_CTRL_PUD_BIT = 0;
    // Values after reset
    localparam logic GPC_RST_BIT = 1'h0;
    localparam logic [31:0] GPC_RST_WORD = 32'h0000_0000;
    // Synchroniser delay for a software-written value, in system clock periods
    localparam int GPC_SW_READBACK_CYCLES = 1;
endpackage
`default_nettype wire

// *** logic/gpc_port.sv ***
// Notes on behaviour
// RQ1: Software going between tri-state and driven high passes through pull-up input or low.
// RQ2: Software going between pull-up input and driven low passes through tri-state or high.
// RQ3: Direction 0, output 1 and pull-up disable 0 give an input with pull-up on.
// RQ4: The global pull-up disable turns off every pull-up, leaving such inputs tri-stated.
// RQ5: The pin level is readable through the input bit whatever the direction.
// RQ6: The pin goes through a falling-edge capture stage and then a rising-edge register.
// RQ7: An external pin change shows in the input bit after one half to one and a half periods.
// RQ8: A software-written value reads back after one period, so software waits one cycle.
// RQ9: In deep sleep the digital input path is clamped to ground before the synchroniser.
// RQ10: A pin enabled as external interrupt source is exempt from the sleep clamp.
// RQ11: A high, non-enabled pin shows a change, and sets its flag, when the clamp is lifted.
// RQ12: Outside deep sleep, including reset, the input path is not clamped.
// RQ13: Reset disables every pull-up, including ones software had enabled.
// RQ14: Direction 1 drives the pin with the output bit value.
// RQ15: Writing a one to an input bit inverts the output bit; a zero does nothing.
// RQ16: Reset tri-states every pin at once, without needing a clock.
// RQ17: Direction, output and pull-up disable bits read zero after reset.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gpc_port #(
    parameter int N = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Sleep controller: high in power-down, power-save and standby
    input wire logic i_deep_sleep,
    // Pins
    input wire logic [N-1:0] i_pin,
    output logic [N-1:0] o_pin,
    output logic [N-1:0] o_pin_oe,
    output logic [N-1:0] o_pullup_en,
    // Interrupt
    output logic o_irq
);
    typedef struct packed {
        logic [N-1:0] pin_direction_bit;
        logic [N-1:0] pin_output_value_bit;
        logic global_pullup_disable;
        logic [N-1:0] ext_int_en;
        logic [N-1:0] irq_stat;
        logic [N-1:0] irq_mask;
        logic [N-1:0] pin_input_sample_bit;
        logic [N-1:0] pin_prev;
        logic [31:0] rdata;
    } gpc_state_t;

    gpc_state_t st_r;
    gpc_state_t st_nxt;
    logic [N-1:0] din;
    logic [N-1:0] sync_fall_r;

    // Widen a pin vector into a bus word, upper bits zero
    function automatic logic [31:0] gpc_word(input logic [N-1:0] v);
        logic [31:0] w;
        w = gpc_pkg::GPC_RST_WORD;
        w[N-1:0] = v;
        return w;
    endfunction

    // Clamp to ground ahead of the synchroniser; interrupt pins keep their input
    assign din = i_pin & ~({N{i_deep_sleep}} & ~st_r.ext_int_en); // see RQ9 see RQ10 see RQ12

    // Capture on the falling edge: same value a high-transparent latch holds at the fall
    always_ff @(negedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            sync_fall_r <= {N{gpc_pkg::GPC_RST_BIT}};
        else
            sync_fall_r <= din; // see RQ6 see RQ7
    end

    // Pin drivers come straight from registers cleared asynchronously, so reset needs no clock
    assign o_pin_oe = st_r.pin_direction_bit; // see RQ14 see RQ16
    assign o_pin = st_r.pin_output_value_bit & st_r.pin_direction_bit; // see RQ14
    assign o_pullup_en = ~st_r.pin_direction_bit & st_r.pin_output_value_bit
        & {N{~st_r.global_pullup_disable}}; // see RQ3 see RQ4 see RQ13
    assign o_rdata = st_r.rdata;
    assign o_irq = |(st_r.irq_stat & st_r.irq_mask);

    // Next state: bus writes, toggle, synchroniser second stage, sticky flags, read data
    always_comb
    begin
        logic [N-1:0] change;
        change = st_r.pin_input_sample_bit ^ st_r.pin_prev;
        st_nxt = st_r;
        st_nxt.pin_input_sample_bit = sync_fall_r; // see RQ6 see RQ5 see RQ8
        st_nxt.pin_prev = st_r.pin_input_sample_bit;
        st_nxt.rdata = gpc_pkg::GPC_RST_WORD;
        if (i_wr)
        begin
            case (i_addr)
                gpc_pkg::GPC_OFF_DIR: st_nxt.pin_direction_bit = i_wdata[N-1:0];
                gpc_pkg::GPC_OFF_OUT: st_nxt.pin_output_value_bit = i_wdata[N-1:0];
                gpc_pkg::GPC_OFF_IN:
                    st_nxt.pin_output_value_bit = st_r.pin_output_value_bit ^ i_wdata[N-1:0]; // see RQ15
                gpc_pkg::GPC_OFF_CTRL:
                    st_nxt.global_pullup_disable = i_wdata[gpc_pkg::GPC_CTRL_PUD_BIT];
                gpc_pkg::GPC_OFF_EXT_EN: st_nxt.ext_int_en = i_wdata[N-1:0];
                gpc_pkg::GPC_OFF_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat & ~i_wdata[N-1:0];
                gpc_pkg::GPC_OFF_IRQ_MASK: st_nxt.irq_mask = i_wdata[N-1:0];
                default: st_nxt.rdata = gpc_pkg::GPC_RST_WORD;
            endcase
        end
        // Set after clear so an edge in the clearing cycle is kept; lifting the clamp counts
        st_nxt.irq_stat = st_nxt.irq_stat | change; // see RQ11
        if (i_rd)
        begin
            case (i_addr)
                gpc_pkg::GPC_OFF_DIR: st_nxt.rdata = gpc_word(st_r.pin_direction_bit);
                gpc_pkg::GPC_OFF_OUT: st_nxt.rdata = gpc_word(st_r.pin_output_value_bit);
                gpc_pkg::GPC_OFF_IN: st_nxt.rdata = gpc_word(st_r.pin_input_sample_bit); // see RQ5
                gpc_pkg::GPC_OFF_CTRL:
                    st_nxt.rdata = {31'h0000_0000, st_r.global_pullup_disable};
                gpc_pkg::GPC_OFF_EXT_EN: st_nxt.rdata = gpc_word(st_r.ext_int_en);
                gpc_pkg::GPC_OFF_IRQ_STAT: st_nxt.rdata = gpc_word(st_r.irq_stat);
                gpc_pkg::GPC_OFF_IRQ_MASK: st_nxt.rdata = gpc_word(st_r.irq_mask);
                default: st_nxt.rdata = gpc_pkg::GPC_RST_WORD;
            endcase
        end
    end

    // State register; everything clears to zero, pins float without pull-up
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            st_r <= '0; // see RQ13 see RQ16 see RQ17
        else
            st_r <= st_nxt;
    end
endmodule
`default_nettype wire

// *** sim/gpc_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpc_board (
    // Pin side of the block and the external driver
    input wire logic i_clk_sys,
    input wire logic [7:0] i_o, i_oe, i_pu, i_ext, i_on,
    output logic [7:0] o_pad
);
    logic [7:0] q_r = 8'h00;
    // A floating line never keeps its old level, so nothing can pass by luck
    always @(posedge i_clk_sys) q_r <= o_pad;
    assign o_pad = (i_oe & i_o) | (~i_oe & i_on & i_ext) | (~i_oe & ~i_on & (i_pu | ~q_r));
endmodule
`default_nettype wire

// *** sim/gpc_port_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpc_port_chk #(parameter int N = 8) (
    // Clock, reset, bus, sleep and pins
    input wire logic i_clk_sys, i_resetn, i_wr, i_rd, i_deep_sleep, o_irq,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata, o_rdata,
    input wire logic [N-1:0] i_pin, o_pin, o_pin_oe, o_pullup_en
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // Writes reach the drivers one edge later
    property p_dir; i_wr && i_addr == gpc_pkg::GPC_OFF_DIR
        |=> o_pin_oe == $past(i_wdata[N-1:0]); endproperty
    a_dir: assert property (p_dir) else $error("dir");
    property p_out; i_wr && i_addr == gpc_pkg::GPC_OFF_OUT
        |=> o_pin == ($past(i_wdata[N-1:0]) & o_pin_oe); endproperty
    a_out: assert property (p_out) else $error("out");
    property p_tog; i_wr && i_addr == gpc_pkg::GPC_OFF_IN
        |=> o_pin == (($past(o_pin) ^ $past(i_wdata[N-1:0])) & o_pin_oe); endproperty
    a_tog: assert property (p_tog) else $error("toggle");
    // Pin captured at the falling edge before the edge ahead of the read edge
    property p_in; i_rd && i_addr == gpc_pkg::GPC_OFF_IN && !i_deep_sleep && !$past(i_deep_sleep)
        |=> o_rdata[N-1:0] == $past(i_pin, 2); endproperty
    a_in: assert property (p_in) else $error("pin read");
    property p_pu; (o_pullup_en & o_pin_oe) == '0; endproperty
    a_pu: assert property (p_pu) else $error("pullup");
    property p_lo; (o_pin & ~o_pin_oe) == '0; endproperty
    a_lo: assert property (p_lo) else $error("idle drive");
    property p_rdz; o_rdata != '0 |-> $past(i_rd); endproperty
    a_rdz: assert property (p_rdz) else $error("rdata");
    property p_rst; disable iff (1'b0) !i_resetn |-> (o_pin_oe | o_pullup_en) == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule
bind gpc_port gpc_port_chk #(.N(N)) i_chk (.*);
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Reset starts released so the first assertion is a real falling edge
    logic clk = 0, rst_n = 1, wr = 0, rd = 0, slp = 0, irq;
    logic [7:0] adr = 8'h00, ext = 8'hff, on = 8'h00, pin, po, oe, pu;
    logic [31:0] wd = 32'h0, rdat;
    int err_count = 0, tests_run = 0;
    // 25 MHz
    always #20 clk = ~clk;
    gpc_port i_dut (.i_clk_sys(clk), .i_resetn(rst_n), .i_addr(adr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdat), .i_deep_sleep(slp), .i_pin(pin), .o_pin(po), .o_pin_oe(oe),
        .o_pullup_en(pu), .o_irq(irq));
    gpc_board i_brd (.i_clk_sys(clk), .i_o(po), .i_oe(oe), .i_pu(pu), .i_ext(ext), .i_on(on),
        .o_pad(pin));
    task automatic ck(input logic [31:0] g, e);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One strobe cycle; read data judged in the cycle after it
    task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w) ck(rdat, d);
    endtask
    // Reset at start and at the end of the run: drivers must drop at once, without a clock edge
    task automatic t_rst;
        rst_n <= 1'b0;
        #1;
        ck(oe | pu, 8'h00);
        repeat (3) @(posedge clk);
        ck(oe | pu, 8'h00);
        rst_n <= 1'b1;
        rg(0, gpc_pkg::GPC_OFF_DIR, 0);
        rg(0, gpc_pkg::GPC_OFF_OUT, 0);
        rg(0, gpc_pkg::GPC_OFF_CTRL, 0);
        rg(0, 8'h1c, 0);
        $display("t_rst done");
    endtask
    task automatic t_io;
        rg(1, gpc_pkg::GPC_OFF_DIR, 32'hff);
        rg(1, gpc_pkg::GPC_OFF_OUT, 32'ha5);
        ck(po, 8'ha5);
        rg(0, gpc_pkg::GPC_OFF_IN, 32'ha5);
        rg(1, gpc_pkg::GPC_OFF_IN, 32'h0f);
        rg(0, gpc_pkg::GPC_OFF_OUT, 32'haa);
        $display("t_io done");
    endtask
    // Low output to pull-up input by way of tri-state
    task automatic t_pull;
        rg(1, gpc_pkg::GPC_OFF_OUT, 0);
        rg(1, gpc_pkg::GPC_OFF_DIR, 0);
        rg(1, gpc_pkg::GPC_OFF_OUT, 32'hff);
        ck(pu, 8'hff);
        rg(0, gpc_pkg::GPC_OFF_IN, 32'hff);
        rg(1, gpc_pkg::GPC_OFF_CTRL, 32'h1 << gpc_pkg::GPC_CTRL_PUD_BIT);
        ck(pu, 8'h00);
        rg(1, gpc_pkg::GPC_OFF_CTRL, 0);
        $display("t_pull done");
    endtask
    // Lower half exempt as interrupt pins, upper half clamped while asleep
    task automatic t_slp;
        on <= 8'hff;
        ext <= 8'hff;
        rg(1, gpc_pkg::GPC_OFF_EXT_EN, 32'h0f);
        rg(1, gpc_pkg::GPC_OFF_IRQ_MASK, 32'hff);
        @(posedge clk);
        slp <= 1'b1;
        // Entering the clamp is itself a change; let it settle before clearing
        repeat (3) @(posedge clk);
        rg(1, gpc_pkg::GPC_OFF_IRQ_STAT, 32'hff);
        rg(0, gpc_pkg::GPC_OFF_IRQ_STAT, 32'h00);
        rg(0, gpc_pkg::GPC_OFF_IN, 32'h0f);
        @(posedge clk);
        slp <= 1'b0;
        repeat (4) @(posedge clk);
        rg(0, gpc_pkg::GPC_OFF_IRQ_STAT, 32'hf0);
        ck(irq, 1);
        rg(0, gpc_pkg::GPC_OFF_IN, 32'hff);
        rg(1, gpc_pkg::GPC_OFF_IRQ_STAT, 32'hff);
        ck(irq, 0);
        $display("t_slp done");
    endtask
    // Counts, verdict and end of run
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        t_rst;
        t_io;
        t_pull;
        t_slp;
        rg(1, gpc_pkg::GPC_OFF_DIR, 32'hff);
        t_rst;
        conclude;
    end
endmodule
`default_nettype wire
